// ==== hdl/mcp_defs.svh ====
`ifndef MCP_DEFS_SVH
`define MCP_DEFS_SVH
// How it works
// - address latched from bus on latch strobe
// - read needs read strobe plus a select
// - write needs write strobe plus a select
// - first select targets disk space; none ignored
// - second select targets SCSI space
// - interrupt lines active high, low when idle
// - disk interrupts raised on command finish or abort, SCSI on its event
// - disk on lines zero/one, SCSI on two
// - open-drain ready; processor waits while low
`define MCP_ADDR_W 8
`define MCP_DATA_W 8
`define MCP_DISK_SPACE 256
`define MCP_SCSI_SPACE 128
`define MCP_WAIT_CYCLES 2
`define MCP_ZERO_BYTE 8'h00
`endif

// ==== hdl/mcp_pkg.sv ====
package mcp_pkg;
  typedef logic [7:0] mcp_byte_t;
  typedef enum logic [1:0] {mcp_none, mcp_disk, mcp_scsi} mcp_space_e;
  typedef enum logic [1:0] {mcp_idle, mcp_wait, mcp_done} mcp_state_e;
endpackage

// ==== hdl/mcp_if.sv ====
interface mcp_if;
  logic latch_strobe;
  logic read_strobe_n;
  logic write_strobe_n;
  logic disk_space_select_n;
  logic scsi_space_select_n;
  logic [7:0] ad_host_out;
  logic ad_host_oe;
  logic [7:0] ad_dev_out;
  logic ad_dev_oe;
  logic ready_low_oe;
  logic disk_irq_a;
  logic disk_irq_b;
  logic scsi_irq;
  wire [7:0] ad_bus = ad_dev_oe ? ad_dev_out : (ad_host_oe ? ad_host_out : 8'hFF);
  wire ready = ~ready_low_oe;
  modport dev (input latch_strobe, input read_strobe_n, input write_strobe_n,
    input disk_space_select_n, input scsi_space_select_n, input ad_bus,
    output ad_dev_out, output ad_dev_oe, output ready_low_oe,
    output disk_irq_a, output disk_irq_b, output scsi_irq);
  modport host (output latch_strobe, output read_strobe_n, output write_strobe_n,
    output disk_space_select_n, output scsi_space_select_n, input ad_bus,
    output ad_host_out, output ad_host_oe, input ready,
    input disk_irq_a, input disk_irq_b, input scsi_irq);
endinterface

// ==== hdl/mcp_device.sv ====
`include "mcp_defs.svh"
module mcp_device #(
  parameter int WAIT_CYCLES = `MCP_WAIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  mcp_if.dev bus,
  output logic [7:0] reg_wr_addr,
  output logic [7:0] reg_wr_data,
  output logic reg_wr_disk,
  output logic reg_wr_scsi,
  input wire logic [7:0] disk_rd_data,
  input wire logic [7:0] scsi_rd_data,
  input wire logic disk_done,
  input wire logic disk_abort,
  input wire logic scsi_event,
  input wire logic irq_clear_disk_a,
  input wire logic irq_clear_disk_b,
  input wire logic irq_clear_scsi
);
  // wait counter width; a longer stretch setting is cut to these bits
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam logic [CNT_W-1:0] WAIT_LOAD = CNT_W'(WAIT_CYCLES);
  // with no stretch the access completes on its first edge
  localparam bit NO_WAIT = (WAIT_LOAD == {CNT_W{1'b0}});

  // active-low pin asserted
  function automatic logic pin_on(input logic pin_n);
    return ~pin_n;
  endfunction

  // register space picked by the selects; disk wins when both are low
  function automatic mcp_pkg::mcp_space_e space_of(input logic disk_n, input logic scsi_n);
    mcp_pkg::mcp_space_e pick;
    if (pin_on(disk_n)) begin
      pick = mcp_pkg::mcp_disk;
    end else if (pin_on(scsi_n)) begin
      pick = mcp_pkg::mcp_scsi;
    end else begin
      pick = mcp_pkg::mcp_none;
    end
    return pick;
  endfunction

  // event-set line held until cleared; set wins over clear
  function automatic logic sticky(input logic set, input logic held, input logic clear);
    return set | (held & ~clear);
  endfunction

  // write pulse of one space, only at the commit edge
  function automatic logic wr_pulse(input logic fire, input logic write, input logic in_space);
    return fire & write & in_space;
  endfunction

  // state, latched address and wait counting
  mcp_pkg::mcp_state_e state;
  mcp_pkg::mcp_state_e next_state;
  mcp_pkg::mcp_space_e space;
  mcp_pkg::mcp_byte_t addr;
  logic [CNT_W-1:0] wait_cnt;
  logic [CNT_W-1:0] next_wait_cnt;
  logic next_ready_low;
  logic commit;

  // qualified access decode
  assign space = space_of(bus.disk_space_select_n, bus.scsi_space_select_n);
  wire sel_disk = (space == mcp_pkg::mcp_disk);
  wire sel_scsi = (space == mcp_pkg::mcp_scsi);
  wire any_sel = sel_disk | sel_scsi;
  wire rd_q = any_sel & pin_on(bus.read_strobe_n);
  wire wr_q = any_sel & pin_on(bus.write_strobe_n);
  wire acc = rd_q | wr_q;
  wire last_wait = (wait_cnt <= CNT_ONE);
  wire [7:0] rd_byte = sel_disk ? disk_rd_data : scsi_rd_data;

  // ready stretch: idle, wait states, done until the strobes drop
  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    next_ready_low = bus.ready_low_oe;
    commit = 1'b0;
    case (state)
      mcp_pkg::mcp_idle: begin
        if (acc) begin
          next_wait_cnt = WAIT_LOAD;
          next_ready_low = ~NO_WAIT;
          commit = NO_WAIT;
          if (NO_WAIT) begin
            next_state = mcp_pkg::mcp_done;
          end else begin
            next_state = mcp_pkg::mcp_wait;
          end
        end
      end
      mcp_pkg::mcp_wait: begin
        if (!acc) begin
          next_ready_low = 1'b0;
          next_state = mcp_pkg::mcp_idle;
        end else if (last_wait) begin
          next_wait_cnt = {CNT_W{1'b0}};
          next_ready_low = 1'b0;
          commit = 1'b1;
          next_state = mcp_pkg::mcp_done;
        end else begin
          next_wait_cnt = wait_cnt - CNT_ONE;
        end
      end
      mcp_pkg::mcp_done: begin
        if (!acc) begin
          next_state = mcp_pkg::mcp_idle;
        end
      end
      default: begin
        next_ready_low = 1'b0;
        next_state = mcp_pkg::mcp_idle;
      end
    endcase
  end

  // sequence state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= mcp_pkg::mcp_idle;
    end else begin
      state <= next_state;
    end
  end

  // wait state counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= {CNT_W{1'b0}};
    end else begin
      wait_cnt <= next_wait_cnt;
    end
  end

  // ready pulled low while wait states run
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus.ready_low_oe <= 1'b0;
    end else begin
      bus.ready_low_oe <= next_ready_low;
    end
  end

  // address latch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr <= `MCP_ZERO_BYTE;
    end else if (bus.latch_strobe) begin
      addr <= bus.ad_bus;
    end
  end

  // read byte onto the shared bus
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus.ad_dev_out <= `MCP_ZERO_BYTE;
    end else begin
      bus.ad_dev_out <= rd_byte;
    end
  end

  // bus drive only in a qualified read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus.ad_dev_oe <= 1'b0;
    end else begin
      bus.ad_dev_oe <= rd_q;
    end
  end

  // write address and data towards the register file
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_wr_addr <= `MCP_ZERO_BYTE;
      reg_wr_data <= `MCP_ZERO_BYTE;
    end else begin
      reg_wr_addr <= addr;
      reg_wr_data <= bus.ad_bus;
    end
  end

  // one-cycle write pulses as ready is released
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_wr_disk <= 1'b0;
      reg_wr_scsi <= 1'b0;
    end else begin
      reg_wr_disk <= wr_pulse(commit, wr_q, sel_disk);
      reg_wr_scsi <= wr_pulse(commit, wr_q, sel_scsi);
    end
  end

  // disk completion line
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus.disk_irq_a <= 1'b0;
    end else begin
      bus.disk_irq_a <= sticky(disk_done, bus.disk_irq_a, irq_clear_disk_a);
    end
  end

  // disk termination line
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus.disk_irq_b <= 1'b0;
    end else begin
      bus.disk_irq_b <= sticky(disk_abort, bus.disk_irq_b, irq_clear_disk_b);
    end
  end

  // scsi event line
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus.scsi_irq <= 1'b0;
    end else begin
      bus.scsi_irq <= sticky(scsi_event, bus.scsi_irq, irq_clear_scsi);
    end
  end
endmodule

// ==== hdl/mcp_host.sv ====
`include "mcp_defs.svh"
module mcp_host (
  input wire logic clk_sys,
  input wire logic rst_n,
  mcp_if.host bus,
  input wire logic req,
  input wire logic req_write,
  input wire logic req_scsi,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic [2:0] irq
);
  typedef enum logic [2:0] {h_idle, h_addr, h_strobe, h_hold, h_wait, h_end} mcp_hstate_e;
  mcp_hstate_e state;
  logic wr;
  logic scsi;
  logic [7:0] wdata;
  // host sequence: latch address, strobe, wait ready, finish
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= h_idle;
      wr <= 1'b0;
      scsi <= 1'b0;
      wdata <= `MCP_ZERO_BYTE;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= `MCP_ZERO_BYTE;
      irq <= 3'h0;
      bus.latch_strobe <= 1'b0;
      bus.read_strobe_n <= 1'b1;
      bus.write_strobe_n <= 1'b1;
      bus.disk_space_select_n <= 1'b1;
      bus.scsi_space_select_n <= 1'b1;
      bus.ad_host_out <= `MCP_ZERO_BYTE;
      bus.ad_host_oe <= 1'b0;
    end else begin
      irq <= {bus.scsi_irq, bus.disk_irq_b, bus.disk_irq_a};
      done <= 1'b0;
      case (state)
        h_idle: begin
          if (req) begin
            wr <= req_write;
            scsi <= req_scsi;
            wdata <= req_wdata;
            busy <= 1'b1;
            bus.ad_host_out <= req_addr;
            bus.ad_host_oe <= 1'b1;
            bus.latch_strobe <= 1'b1;
            state <= h_addr;
          end
        end
        h_addr: begin
          bus.latch_strobe <= 1'b0;
          bus.ad_host_out <= wdata;
          bus.ad_host_oe <= wr;
          bus.disk_space_select_n <= scsi;
          bus.scsi_space_select_n <= ~scsi;
          state <= h_strobe;
        end
        h_strobe: begin
          bus.read_strobe_n <= wr;
          bus.write_strobe_n <= ~wr;
          state <= h_hold;
        end
        // device answers one edge after the strobe; skip that edge
        h_hold: begin
          state <= h_wait;
        end
        h_wait: begin
          if (bus.ready) begin
            rdata <= bus.ad_bus;
            bus.read_strobe_n <= 1'b1;
            bus.write_strobe_n <= 1'b1;
            state <= h_end;
          end
        end
        h_end: begin
          bus.disk_space_select_n <= 1'b1;
          bus.scsi_space_select_n <= 1'b1;
          bus.ad_host_oe <= 1'b0;
          busy <= 1'b0;
          done <= 1'b1;
          state <= h_idle;
        end
        default: state <= h_idle;
      endcase
    end
  end
endmodule

// ==== testbench/mcp_port_props.sv ====
module mcp_port_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic latch_strobe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic disk_space_select_n,
  input wire logic scsi_space_select_n,
  input wire logic ad_dev_oe,
  input wire logic ready_low_oe,
  input wire logic disk_irq_a,
  input wire logic disk_irq_b,
  input wire logic scsi_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // qualified strobes
  wire sel = !disk_space_select_n || !scsi_space_select_n;
  wire q_rd = sel && !read_strobe_n;
  wire acc = sel && !(read_strobe_n && write_strobe_n);
  sequence s_wait;
    ready_low_oe ##[1:3] !ready_low_oe;
  endsequence
  property p_oe_cause;
    ad_dev_oe |-> q_rd || $past(q_rd);
  endproperty
  property p_oe_read;
    q_rd [*2] |-> ad_dev_oe;
  endproperty
  property p_wr_quiet;
    !write_strobe_n |-> !ad_dev_oe;
  endproperty
  property p_latch_quiet;
    latch_strobe |-> !ad_dev_oe;
  endproperty
  property p_ready_go;
    $rose(acc) |-> ##[1:2] s_wait;
  endproperty
  property p_ready_end;
    ready_low_oe |-> ##[1:3] !ready_low_oe;
  endproperty
  property p_ready_cause;
    ready_low_oe |-> acc || $past(acc);
  endproperty
  property p_irq_rst;
    $rose(rst_n) |-> !(disk_irq_a || disk_irq_b || scsi_irq);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("bus driven outside read");
  a_oe_read: assert property (p_oe_read) else $error("read not driven");
  a_wr_quiet: assert property (p_wr_quiet) else $error("bus driven in write");
  a_latch_quiet: assert property (p_latch_quiet) else $error("bus driven in latch");
  a_ready_go: assert property (p_ready_go) else $error("ready wait missing");
  a_ready_end: assert property (p_ready_end) else $error("ready stuck low");
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
  a_irq_rst: assert property (p_irq_rst) else $error("irq high after reset");
endmodule

// ==== testbench/tb_muxed_cpu_register_port.sv ====
module tb_muxed_cpu_register_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0, req_write = 1'b0, req_scsi = 1'b0, busy, done, wr_disk, wr_scsi;
  logic [7:0] req_addr = 8'h00, req_wdata = 8'h00, rdata, wr_addr, wr_data;
  logic [2:0] ev = 3'h0, clr = 3'h0, irq;
  logic [16:0] cap = 17'h00000;
  int n_mismatch = 0, samples_checked = 0;
  mcp_if mcp_if_i ();
  mcp_device mcp_device_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(mcp_if_i.dev),
    .reg_wr_addr(wr_addr), .reg_wr_data(wr_data), .reg_wr_disk(wr_disk), .reg_wr_scsi(wr_scsi),
    .disk_rd_data(8'hA5), .scsi_rd_data(8'h5A), .disk_done(ev[0]), .disk_abort(ev[1]),
    .scsi_event(ev[2]), .irq_clear_disk_a(clr[0]), .irq_clear_disk_b(clr[1]),
    .irq_clear_scsi(clr[2]));
  mcp_host mcp_host_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(mcp_if_i.host), .req(req),
    .req_write(req_write), .req_scsi(req_scsi), .req_addr(req_addr), .req_wdata(req_wdata),
    .busy(busy), .done(done), .rdata(rdata), .irq(irq));
  mcp_port_props mcp_port_props_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .latch_strobe(mcp_if_i.latch_strobe), .read_strobe_n(mcp_if_i.read_strobe_n),
    .write_strobe_n(mcp_if_i.write_strobe_n),
    .disk_space_select_n(mcp_if_i.disk_space_select_n),
    .scsi_space_select_n(mcp_if_i.scsi_space_select_n), .ad_dev_oe(mcp_if_i.ad_dev_oe),
    .ready_low_oe(mcp_if_i.ready_low_oe), .disk_irq_a(mcp_if_i.disk_irq_a),
    .disk_irq_b(mcp_if_i.disk_irq_b), .scsi_irq(mcp_if_i.scsi_irq));
  // free-running clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // capture each register write pulse
  always @(posedge clk_sys) begin
    if (wr_disk || wr_scsi)
      cap <= {wr_scsi, wr_addr, wr_data};
  end
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one host access, bounded wait on done
  task automatic acc(input logic w, input logic s, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_sys);
    {req, req_write, req_scsi, req_addr, req_wdata} <= {1'b1, w, s, a, d};
    @(posedge clk_sys);
    req <= 1'b0;
    k = 0;
    while (k < 40 && done !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (done !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    acc(1'b1, 1'b0, 8'h5A, 8'hC3);
    chk(cap, 17'h05AC3);
    chk({16'h0000, busy}, 17'h00000);
    acc(1'b1, 1'b1, 8'h81, 8'h3C);
    chk(cap, 17'h1813C);
    $display("test write done");
    acc(1'b0, 1'b0, 8'h10, 8'h00);
    chk({9'h000, rdata}, 17'h000A5);
    acc(1'b0, 1'b1, 8'h10, 8'h00);
    chk({9'h000, rdata}, 17'h0005A);
    chk(cap, 17'h1813C);
    $display("test read done");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      ev[i] <= 1'b1;
      @(posedge clk_sys);
      ev <= 3'h0;
      repeat (3) @(posedge clk_sys);
      #1;
      chk({14'h0000, irq}, (17'h00002 << i) - 17'h00001);
    end
    @(posedge clk_sys);
    clr <= 3'h7;
    @(posedge clk_sys);
    clr <= 3'h0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk({14'h0000, irq}, 17'h00000);
    @(posedge clk_sys);
    {ev, clr} <= {3'h7, 3'h7};
    @(posedge clk_sys);
    {ev, clr} <= {3'h0, 3'h0};
    repeat (3) @(posedge clk_sys);
    #1;
    chk({14'h0000, irq}, 17'h00007);
    $display("test irq done");
    wrap_up();
  end
endmodule
